// ### design/boot_pin_pkg.sv
`default_nettype none
package boot_pin_pkg;
	localparam int unsigned NUM_PINS = 60;
	// Boot-select input pin positions
	localparam int unsigned SEL0_PIN = 30;
	localparam int unsigned SEL1_PIN = 31;
	localparam int unsigned SEL2_PIN = 32;
	// Special pin positions
	localparam int unsigned MUX_CLK_PIN   = 16;
	localparam int unsigned MUX_OUT_PIN   = 21;
	localparam int unsigned FAIL_HI_PIN   = 45;
	localparam int unsigned FAIL_LO_PIN   = 50;
	localparam int unsigned SPI_SCLK_PIN  = 53;
	localparam int unsigned I2C_SCL_PIN   = 58;
	localparam int unsigned I2C_SDA_PIN   = 59;
	// Fixed masks: bit set means the pin is driven (oe), drives high (level) or is a muxed-bus input (in)
	localparam logic [59:0] ALL_OE_MASK   = 60'h008_0400_0000_0000;
	localparam logic [59:0] SPI_OE_MASK   = 60'h371_4000_0000_0000;
	localparam logic [59:0] SPI_HI_MASK   = 60'h051_4000_0000_0000;
	localparam logic [59:0] OTH_OE_MASK   = 60'h0A0_2000_0000_0000;
	localparam logic [59:0] OTH_HI_MASK   = 60'h0A0_2000_0000_0000;
	localparam logic [59:0] MUX_IN_MASK   = 60'h000_0000_089E_0000;
	// Boot-select encodings
	typedef enum logic [1:0] {
		mode_spi,
		mode_usb,
		mode_i2c,
		mode_muxbus
	} boot_mode_t;
	localparam logic [2:0] SEL_SPI_A = 3'h1;
	localparam logic [2:0] SEL_SPI_B = 3'h5;
	localparam logic [2:0] SEL_I2C_A = 3'h2;
	localparam logic [2:0] SEL_I2C_B = 3'h6;
	localparam logic [2:0] SEL_MUX   = 3'h0;
endpackage
`default_nettype wire

// ### design/boot_mode_decode.sv
`default_nettype none
module boot_mode_decode
	import boot_pin_pkg::*;
(
	input  wire logic [2:0] boot_select,
	output boot_mode_t      mode
);
	// Map the three select straps onto a boot mode; others fall to USB
	always_comb begin
		unique case (boot_select)
			SEL_SPI_A, SEL_SPI_B: mode = mode_spi;
			SEL_I2C_A, SEL_I2C_B: mode = mode_i2c;
			SEL_MUX:              mode = mode_muxbus;
			default:              mode = mode_usb;
		endcase
	end
endmodule
`default_nettype wire

// ### design/boot_mode_pin_defaults.sv
`default_nettype none
module boot_mode_pin_defaults
	import boot_pin_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [59:0] pin_in,
	input  wire logic        fw_takeover,
	input  wire logic        spi_boot_fail,
	input  wire logic        spi_sclk,
	input  wire logic        spi_active,
	input  wire logic        i2c_scl_drive_low,
	input  wire logic        i2c_sda_drive_low,
	input  wire logic        i2c_active,
	input  wire logic        muxbus_out,
	output logic      [59:0] pin_out,
	output logic      [59:0] pin_oe,
	output logic      [2:0]  boot_select_r,
	output logic             muxbus_clk_r,
	output logic      [5:0]  muxbus_in_r,
	output logic             mode_valid_r,
	output logic      [1:0]  boot_mode_r,
	output logic             loader_active_r
);
	boot_mode_t mode_dec;
	boot_mode_t mode_r;
	logic       fail_r;
	logic [59:0] pin_out_nxt;
	logic [59:0] pin_oe_nxt;

	// Decode the live straps so the mode is latched together with them
	boot_mode_decode u_dec (
		.boot_select ({pin_in[SEL2_PIN], pin_in[SEL1_PIN], pin_in[SEL0_PIN]}),
		.mode        (mode_dec)
	);

	// Straps and mode latched once; avoids a stale-mode pattern in the first cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			boot_select_r <= 3'h0;
			mode_valid_r  <= 1'b0;
			mode_r        <= mode_usb;
		end else if (!mode_valid_r) begin
			boot_select_r <= {pin_in[SEL2_PIN], pin_in[SEL1_PIN], pin_in[SEL0_PIN]};
			mode_valid_r  <= 1'b1;
			mode_r        <= mode_dec;
		end
	end

	// Loader phase ends for good when firmware claims the pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			loader_active_r <= 1'b1;
		end else if (fw_takeover && mode_valid_r) begin
			loader_active_r <= 1'b0;
		end
	end

	// Sticky SPI failure flag; set only in SPI mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fail_r <= 1'b0;
		end else if (spi_boot_fail && mode_r == mode_spi && mode_valid_r) begin
			fail_r <= 1'b1;
		end
	end

	// Build the pattern for the latched mode
	always_comb begin
		pin_oe_nxt  = ALL_OE_MASK;
		pin_out_nxt = '0;
		unique case (mode_r)
			mode_spi: begin
				pin_oe_nxt  = pin_oe_nxt | SPI_OE_MASK;
				pin_out_nxt = SPI_HI_MASK;
				pin_out_nxt[SPI_SCLK_PIN] = spi_active & spi_sclk;
				pin_oe_nxt[FAIL_HI_PIN]   = fail_r;
				pin_out_nxt[FAIL_HI_PIN]  = fail_r;
				pin_oe_nxt[FAIL_LO_PIN]   = fail_r;
			end
			mode_muxbus: begin
				pin_oe_nxt  = pin_oe_nxt | OTH_OE_MASK;
				pin_out_nxt = OTH_HI_MASK;
				pin_oe_nxt[MUX_OUT_PIN]  = 1'b1;
				pin_out_nxt[MUX_OUT_PIN] = muxbus_out;
			end
			mode_i2c: begin
				pin_oe_nxt  = pin_oe_nxt | OTH_OE_MASK;
				pin_out_nxt = OTH_HI_MASK;
				pin_oe_nxt[I2C_SCL_PIN] = i2c_active & i2c_scl_drive_low;
				pin_oe_nxt[I2C_SDA_PIN] = i2c_active & i2c_sda_drive_low;
			end
			mode_usb: begin
				pin_oe_nxt  = pin_oe_nxt | OTH_OE_MASK;
				pin_out_nxt = OTH_HI_MASK;
			end
		endcase
		if (!mode_valid_r) begin
			pin_oe_nxt  = '0;
			pin_out_nxt = '0;
		end
	end

	// Register pins; released to tristate once firmware owns them
	always_ff @(posedge ref_clk) begin
		if (rst || !loader_active_r) begin
			pin_oe  <= '0;
			pin_out <= '0;
		end else begin
			pin_oe  <= pin_oe_nxt;
			pin_out <= pin_out_nxt;
		end
	end

	// Sample muxed-bus clock and inputs only in muxed mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			muxbus_clk_r <= 1'b0;
			muxbus_in_r  <= 6'h00;
			boot_mode_r  <= 2'h0;
		end else begin
			boot_mode_r <= mode_r;
			if (mode_r == mode_muxbus && loader_active_r) begin
				muxbus_clk_r <= pin_in[MUX_CLK_PIN];
				muxbus_in_r  <= {pin_in[27], pin_in[23], pin_in[20:17]};
			end else begin
				muxbus_clk_r <= 1'b0;
				muxbus_in_r  <= 6'h00;
			end
		end
	end

	// Checks
	property p_mid_tristate;
		@(posedge ref_clk) disable iff (rst) (pin_oe & 60'h002_9BFE_3740_FFFF) == '0;
	endproperty
	a_mid_tristate: assert property (p_mid_tristate) else $error("general pin driven");
	property p_low_pins;
		@(posedge ref_clk) disable iff (rst) loader_active_r && $past(mode_valid_r) && $past(loader_active_r) |->
			pin_oe[42] && pin_oe[51] && !pin_out[42] && !pin_out[51];
	endproperty
	a_low_pins: assert property (p_low_pins) else $error("pins 42/51 not low");
	property p_sel_inputs;
		@(posedge ref_clk) disable iff (rst) !pin_oe[30] && !pin_oe[31] && !pin_oe[32];
	endproperty
	a_sel_inputs: assert property (p_sel_inputs) else $error("select pin driven");
	property p_mode_stable;
		@(posedge ref_clk) disable iff (rst) $past(mode_valid_r) && mode_valid_r |-> $stable(boot_select_r);
	endproperty
	a_mode_stable: assert property (p_mode_stable) else $error("select changed");
	property p_spi_high;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_spi && mode_valid_r && loader_active_r ##1 loader_active_r
			|-> pin_oe[46] && pin_out[46] && pin_oe[54] && pin_oe[56] && !pin_out[56];
	endproperty
	a_spi_high: assert property (p_spi_high) else $error("SPI pattern wrong");
	property p_fail;
		@(posedge ref_clk) disable iff (rst) fail_r && mode_r == mode_spi ##1 loader_active_r
			|-> pin_oe[45] && pin_out[45] && pin_oe[50] && !pin_out[50];
	endproperty
	a_fail: assert property (p_fail) else $error("fail pins wrong");
	property p_release;
		@(posedge ref_clk) disable iff (rst) !loader_active_r |=> pin_oe == '0;
	endproperty
	a_release: assert property (p_release) else $error("pins held after takeover");
	property p_other_55;
		@(posedge ref_clk) disable iff (rst) mode_r != mode_spi && mode_valid_r && loader_active_r ##1 loader_active_r
			|-> pin_oe[55] && pin_out[55] && pin_out[53] && !pin_oe[46];
	endproperty
	a_other_55: assert property (p_other_55) else $error("non-SPI pattern wrong");
	property p_clk_in;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_muxbus && loader_active_r
			|=> !pin_oe[MUX_CLK_PIN] && muxbus_clk_r == $past(pin_in[MUX_CLK_PIN]);
	endproperty
	a_clk_in: assert property (p_clk_in) else $error("muxed clock input not sampled");
	property p_bus_inputs;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_muxbus && loader_active_r
			|=> (pin_oe & MUX_IN_MASK) == '0
			&& muxbus_in_r == {$past(pin_in[27]), $past(pin_in[23]), $past(pin_in[20:17])};
	endproperty
	a_bus_inputs: assert property (p_bus_inputs) else $error("muxed inputs wrong");
	property p_bus_out;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_muxbus && mode_valid_r && loader_active_r
			|=> pin_oe[MUX_OUT_PIN] && pin_out[MUX_OUT_PIN] == $past(muxbus_out);
	endproperty
	a_bus_out: assert property (p_bus_out) else $error("muxed output pin wrong");
	property p_fail_low;
		@(posedge ref_clk) disable iff (rst) pin_oe[FAIL_LO_PIN] |-> !pin_out[FAIL_LO_PIN] && $past(fail_r);
	endproperty
	a_fail_low: assert property (p_fail_low) else $error("pin 50 driven without SPI failure");
	property p_spi_low;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_spi && mode_valid_r && loader_active_r
			|=> pin_oe[56] && !pin_out[56] && pin_oe[57] && !pin_out[57] && !pin_oe[55] && pin_out[54];
	endproperty
	a_spi_low: assert property (p_spi_low) else $error("SPI low pins wrong");
	property p_spi_clk;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_spi && mode_valid_r && loader_active_r
			|=> pin_oe[SPI_SCLK_PIN] && pin_out[SPI_SCLK_PIN] == ($past(spi_active) && $past(spi_sclk));
	endproperty
	a_spi_clk: assert property (p_spi_clk) else $error("SPI clock pin wrong");
	property p_i2c_pins;
		@(posedge ref_clk) disable iff (rst) mode_r == mode_i2c && mode_valid_r && loader_active_r
			|=> pin_oe[I2C_SCL_PIN] == ($past(i2c_active) && $past(i2c_scl_drive_low))
			&& pin_oe[I2C_SDA_PIN] == ($past(i2c_active) && $past(i2c_sda_drive_low))
			&& !pin_out[I2C_SCL_PIN] && !pin_out[I2C_SDA_PIN];
	endproperty
	a_i2c_pins: assert property (p_i2c_pins) else $error("I2C pins wrong");
	property p_i2c_idle;
		@(posedge ref_clk) disable iff (rst) mode_r != mode_i2c
			|=> !pin_oe[I2C_SCL_PIN] && !pin_oe[I2C_SDA_PIN];
	endproperty
	a_i2c_idle: assert property (p_i2c_idle) else $error("I2C pins driven outside I2C mode");
endmodule
`default_nettype wire

// ### tb/board_far_side.sv
`default_nettype none
// Board side: strap resistors, pull-ups on the I2C pair, free levels elsewhere
module board_far_side (
	input  wire logic [2:0]  strap,
	input  wire logic [59:0] ext_lvl,
	input  wire logic [59:0] pin_out,
	input  wire logic [59:0] pin_oe,
	output logic      [59:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Device drive wins on a pad except the strap pins, otherwise the board level shows
	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & {2'h3, ext_lvl[57:0]});
		pin_in[32:30] = strap;
	end
endmodule
`default_nettype wire

// ### tb/tb_boot_mode_pin_defaults.sv
`default_nettype none
module tb_boot_mode_pin_defaults
	import boot_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk, rst, fw_takeover, spi_boot_fail, spi_sclk, spi_active, muxbus_out, fail;
	logic        i2c_scl_drive_low, i2c_sda_drive_low, i2c_active, muxbus_clk_r, mode_valid_r, loader_active_r;
	logic [1:0]  boot_mode_r;
	logic [2:0]  strap, boot_select_r;
	logic [5:0]  muxbus_in_r;
	logic [59:0] ext_lvl, pin_in, pin_out, pin_oe, exp_oe, exp_out;
	int          mismatches, check_count, cycles, mode, sel;

	boot_mode_pin_defaults DUT (.ref_clk, .rst, .pin_in, .fw_takeover, .spi_boot_fail, .spi_sclk, .spi_active,
		.i2c_scl_drive_low, .i2c_sda_drive_low, .i2c_active, .muxbus_out, .pin_out, .pin_oe, .boot_select_r,
		.muxbus_clk_r, .muxbus_in_r, .mode_valid_r, .boot_mode_r, .loader_active_r);
	board_far_side far (.strap, .ext_lvl, .pin_out, .pin_oe, .pin_in);

	// Core clock
	always #50 ref_clk = ~ref_clk;

	// Cuts a hung run short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		check_count++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t value seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Random inputs held for two edges, then the pads are compared with the model
	task automatic step(input int i);
		@(posedge ref_clk);
		#5;
		{spi_sclk, spi_active, i2c_scl_drive_low, i2c_sda_drive_low, i2c_active, muxbus_out} = 6'($urandom);
		spi_boot_fail = (i > 0) && ($urandom % 4 == 0);
		ext_lvl = 60'({$urandom, $urandom});
		strap = 3'($urandom);
		if (mode == 0 && spi_boot_fail)
			fail = 1'h1;
		repeat (2) @(posedge ref_clk);
		#1;
		exp_oe = 60'h0;
		exp_out = 60'h0;
		exp_oe[42] = 1'h1;
		exp_oe[51] = 1'h1;
		if (mode == 0) begin
			for (int p = 46; p < 58; p++) begin
				if (p inside {46, 48, 52, 54, 56, 57}) begin
					exp_oe[p] = 1'h1;
					exp_out[p] = (p < 55);
				end
			end
			exp_oe[53] = 1'h1;
			exp_out[53] = spi_active & spi_sclk;
			exp_oe[45] = fail;
			exp_out[45] = fail;
			exp_oe[50] = fail;
		end else begin
			exp_oe[55:53] = 3'h5;
			exp_out[55:53] = 3'h5;
			exp_oe[45] = 1'h1;
			exp_out[45] = 1'h1;
		end
		if (mode == 2) begin
			exp_oe[58] = i2c_active & i2c_scl_drive_low;
			exp_oe[59] = i2c_active & i2c_sda_drive_low;
		end
		if (mode == 3) begin
			exp_oe[21] = 1'h1;
			exp_out[21] = muxbus_out;
		end
		check(pin_oe, exp_oe);
		check(pin_out & pin_oe, exp_out);
		check(boot_mode_r, mode);
		check({mode_valid_r, boot_select_r}, 8 + sel);
		check({muxbus_clk_r, muxbus_in_r}, (mode == 3) ? {ext_lvl[16], ext_lvl[27], ext_lvl[23], ext_lvl[20:17]} : 7'h0);
	endtask

	// Every strap code, each run ending with firmware taking the pads
	initial begin
		{ref_clk, fw_takeover, spi_boot_fail, spi_sclk, spi_active, muxbus_out, fail} = 7'h0;
		{i2c_scl_drive_low, i2c_sda_drive_low, i2c_active, rst, strap} = 7'h8;
		ext_lvl = 60'h0;
		void'($urandom(87586));
		for (sel = 0; sel < 8; sel++) begin
			mode = (sel == 0) ? 3 : (sel % 4 == 1) ? 0 : (sel % 4 == 2) ? 2 : 1;
			fail = 1'h0;
			rst = 1'h1;
			strap = 3'(sel);
			repeat (3) @(posedge ref_clk);
			#1;
			check({loader_active_r, pin_oe}, 64'h1000_0000_0000_0000);
			#4;
			rst = 1'h0;
			for (int i = 0; i < 6; i++)
				step(i);
			@(posedge ref_clk);
			#5;
			fw_takeover = 1'h1;
			repeat (2) @(posedge ref_clk);
			#1;
			check({loader_active_r, pin_oe}, 64'h0);
			#4;
			fw_takeover = 1'h0;
			$display("test with strap %0d done", sel);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
